// *** inc/wct_pkg.sv ***
// watchdog control and timeout: shared constants, types and helpers
// assumes a 32-bit classic wishbone bus and one 100 MHz core clock
package wct_pkg;

	// register byte offsets
	localparam logic [7:0] A_CTRL  = 8'h00; // control and status
	localparam logic [7:0] A_RSTAT = 8'h04; // reset status
	localparam logic [7:0] A_ISTAT = 8'h08; // event status, read only
	localparam logic [7:0] A_ICLR  = 8'h0C; // event clear, write only
	localparam logic [7:0] A_IEN   = 8'h10; // event enable

	// control and status field positions
	localparam int B_FLAG = 7;
	localparam int B_IE   = 6;
	localparam int B_P3   = 5;
	localparam int B_CE   = 4;
	localparam int B_WDE  = 3;
	localparam int B_WATCHDOG_RESET_FLAG = 0; // in reset status

	// event bits
	localparam int EV_TOUT = 0;
	localparam int EV_SRST = 1;

	// reset values and timing
	localparam logic [7:0]  CTRL_RESET   = 8'h00;
	localparam logic [1:0]  EV_RESET     = 2'h0;
	localparam logic [2:0]  CE_WINDOW    = 3'h4;
	localparam int          TIMEOUT_BASE = 2048;
	localparam logic [3:0]  PS_MAX       = 4'h9;

	typedef enum logic [3:0] {
		M_STOP = 4'h1,
		M_INT  = 4'h2,
		M_RST  = 4'h4,
		M_BOTH = 4'h8
	} wct_mode_type;

	typedef struct packed {
		logic       run;
		logic       restart;
		logic [3:0] code;
	} wct_cnt_cfg_type;

	// timeout period in oscillator cycles; reserved codes use the longest
	function automatic logic [20:0] wct_limit(input logic [3:0] code, input logic [20:0] base);
		logic [3:0] c;
		c = (code > PS_MAX) ? PS_MAX : code;
		return base << c;
	endfunction

	// operating mode from fuse and effective enables
	function automatic wct_mode_type wct_mode_of(input logic fuse, input logic system_reset_enable,
		input logic ie);
		wct_mode_type m;
		m = M_STOP;
		if (fuse) begin
			m = M_RST;
		end else begin
			case ({system_reset_enable, ie})
				2'b01: m = M_INT;
				2'b10: m = M_RST;
				2'b11: m = M_BOTH;
				default: m = M_STOP;
			endcase
		end
		return m;
	endfunction

endpackage

// *** rtl/wct_counter.sv ***
// watchdog control and timeout: oscillator cycle counter
// assumes tick is a one-cycle pulse per oscillator period
`timescale 1ns/100ps
module wct_counter
	import wct_pkg::*;
#(
	parameter logic [20:0] BASE = 21'(TIMEOUT_BASE)
)(
	// clock and reset
	input  wire logic            clk,
	input  wire logic            rst,
	// oscillator tick and configuration
	input  wire logic            tick,
	input  wct_cnt_cfg_type      cfg,
	// one-cycle timeout pulse
	output wire logic            tout
);
	typedef struct packed {
		logic [19:0] cnt;
		logic        tout;
	} wct_cnt_st_type;

	wct_cnt_st_type s_r;
	wct_cnt_st_type s_nxt;
	logic [20:0]    lim;

	// count oscillator ticks, wrap on timeout
	always_comb begin
		s_nxt      = s_r;
		s_nxt.tout = 1'b0;
		// RL13 period from code
		lim = wct_limit(cfg.code, BASE);
		// RL19 restart clears count
		if (!cfg.run || cfg.restart) begin
			s_nxt.cnt = '0;
		end else if (tick) begin
			// RL16 timeout on count reached
			if ({1'b0, s_r.cnt} >= lim - 21'h000001) begin
				s_nxt.cnt  = '0;
				s_nxt.tout = 1'b1;
			end else begin
				s_nxt.cnt = s_r.cnt + 20'h00001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tout = s_r.tout;
endmodule

// *** rtl/wct_sync.sv ***
// watchdog control and timeout: oscillator edge synchroniser
// assumes osc_in is unrelated to clk and far slower than it
`timescale 1ns/100ps
module wct_sync
	import wct_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// oscillator level in, one-cycle rise out
	input  wire logic osc_in,
	output wire logic osc_rise
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} wct_sync_st_type;

	wct_sync_st_type s_r;
	wct_sync_st_type s_nxt;

	// two flops for the level, a third only for edge detection
	always_comb begin
		s_nxt    = s_r;
		s_nxt.s1 = osc_in;
		s_nxt.s2 = s_r.s1;
		s_nxt.s3 = s_r.s2;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign osc_rise = s_r.s2 & ~s_r.s3;
endmodule

// *** rtl/wct_watchdog.sv ***
// watchdog control and timeout: top with register slave and mode logic
// assumes classic wishbone master, core pulses for vector and restart
//
// Added by the designer: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/100ps
// What this block does
// RL1: timeout in interrupt operation sets flag
// RL2: vector execution or writing one clears flag
// RL3: request needs global enable, enable, flag
// RL4: interrupt only mode interrupts every timeout
// RL5: combined mode first timeout sets flag only
// RL6: combined vector clears enable and flag
// RL7: unserviced second timeout gives system reset
// RL8: software re-arms enable outside service routine
// RL9: combined mode: interrupt, then reset operation
// RL10: clear reset enable, prescaler need change enable
// RL11: change enable self-clears after four cycles
// RL12: reset flag forces reset enable set
// RL13: prescaler selects 2048 doubled per step
// RL14: no enables stops; reset enable resets
// RL15: oscillator events synchronised into core clock
// RL16: counter counts own oscillator, signals timeout
// RL17: protected change is two writes, four cycles
// RL18: fuse forces reset mode, enable locked
// RL19: restart instruction clears the counter
module wct_watchdog
	import wct_pkg::*;
#(
	parameter int BASE_CYCLES = TIMEOUT_BASE
)(
	// clock and reset
	input  wire logic        SYS_CLK,
	input  wire logic        RST,
	// wishbone slave
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [7:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output wire logic [31:0] WB_DAT_O,
	output wire logic        WB_ACK_O,
	// watchdog oscillator and fuse
	input  wire logic        WDT_OSC,
	input  wire logic        ALWAYS_ON_FUSE,
	// core side
	input  wire logic        WDR_EXEC,
	input  wire logic        VECTOR_ACK,
	input  wire logic        GLOBAL_IE,
	output wire logic        TIMEOUT_IRQ_REQ,
	output wire logic        SYS_RESET_REQ,
	output wire logic        IRQ
);
	typedef struct packed {
		logic       ack;
		logic [7:0] rdat;
		logic       flag;
		logic       ie;
		logic [3:0] ps;
		logic       system_reset_enable;
		logic [2:0] win;
		logic       watchdog_reset_flag;
		logic [1:0] ist;
		logic [1:0] ien;
		logic       srst;
	} wct_st_type;

	wct_st_type      s_r;
	wct_st_type      s_nxt;
	wct_cnt_cfg_type cfg;
	wct_mode_type    mode;
	logic            tick;
	logic            tout;
	logic            req;
	logic            wr;
	logic [7:0]      adr;
	logic [7:0]      d;
	logic            win_open;
	logic            wde_eff;
	logic            ie_eff;
	logic [7:0]      ctrl_rd;

	// RL15 oscillator into core domain
	wct_sync u_sync (
		.clk      (SYS_CLK),
		.rst      (RST),
		.osc_in   (WDT_OSC),
		.osc_rise (tick)
	);

	wct_counter #(
		.BASE (21'(BASE_CYCLES))
	) u_cnt (
		.clk  (SYS_CLK),
		.rst  (RST),
		.tick (tick),
		.cfg  (cfg),
		.tout (tout)
	);

	// bus decode and effective control bits
	assign req      = WB_CYC_I & WB_STB_I;
	assign wr       = req & s_r.ack & WB_WE_I & WB_SEL_I[0];
	assign adr      = {WB_ADR_I[7:2], 2'b00};
	assign d        = WB_DAT_I[7:0];
	assign win_open = (s_r.win != 3'h0);
	// RL12 reset flag overrides enable
	assign wde_eff  = s_r.system_reset_enable | s_r.watchdog_reset_flag | ALWAYS_ON_FUSE;
	// RL18 fuse locks enable low
	assign ie_eff   = s_r.ie & ~ALWAYS_ON_FUSE;
	assign mode     = wct_mode_of(ALWAYS_ON_FUSE, wde_eff, ie_eff);
	assign ctrl_rd  = {s_r.flag, ie_eff, s_r.ps[3], win_open, wde_eff, s_r.ps[2:0]};

	// counter control
	assign cfg.run     = (mode != M_STOP);
	assign cfg.restart = WDR_EXEC | s_r.srst;
	assign cfg.code    = s_r.ps;

	// next state: bus, control writes, vector, timeout
	// order matters: later steps override earlier ones, so a timeout
	// event always beats a software clear or a vector in the same cycle,
	// and a reset request can never be lost to a racing flag write
	always_comb begin
		s_nxt      = s_r;
		s_nxt.srst = 1'b0;
		s_nxt.ack  = req & ~s_r.ack;
		// read data latched as ack is raised
		if (req && !s_r.ack) begin
			case (adr)
				A_CTRL:  s_nxt.rdat = ctrl_rd;
				A_RSTAT: s_nxt.rdat = {7'h00, s_r.watchdog_reset_flag};
				A_ISTAT: s_nxt.rdat = {6'h00, s_r.ist};
				A_IEN:   s_nxt.rdat = {6'h00, s_r.ien};
				default: s_nxt.rdat = 8'h00;
			endcase
		end
		// RL11 change window counts down
		s_nxt.win = win_open ? s_r.win - 3'h1 : 3'h0;
		if (wr) begin
			case (adr)
				A_CTRL: begin
					// RL2 write one clears flag
					if (d[B_FLAG]) begin
						s_nxt.flag = 1'b0;
					end
					s_nxt.ie = d[B_IE] & ~ALWAYS_ON_FUSE;
					// RL17 change enable opens window
					if (d[B_CE]) begin
						s_nxt.win = CE_WINDOW;
					end
					// RL10 clear only inside window
					if (d[B_WDE]) begin
						s_nxt.system_reset_enable = 1'b1;
					end else if (win_open && !d[B_CE] && !s_r.watchdog_reset_flag) begin
						s_nxt.system_reset_enable = 1'b0;
					end
					// RL10 prescaler only inside window
					if (win_open) begin
						s_nxt.ps = {d[B_P3], d[2:0]};
					end
				end
				A_RSTAT: begin
					if (!d[B_WATCHDOG_RESET_FLAG]) begin
						s_nxt.watchdog_reset_flag = 1'b0;
					end
				end
				A_ICLR:  s_nxt.ist = s_r.ist & ~d[1:0];
				A_IEN:   s_nxt.ien = d[1:0];
				default: s_nxt.ist = s_nxt.ist;
			endcase
		end
		// RL2 vector execution clears flag
		if (VECTOR_ACK) begin
			s_nxt.flag = 1'b0;
			// RL6 combined falls back to reset
			if (mode == M_BOTH) begin
				s_nxt.ie = 1'b0;
			end
		end
		// timeout actions, set wins over clears
		if (tout) begin
			s_nxt.ist[EV_TOUT] = 1'b1;
			case (mode)
				// RL4 interrupt only mode
				M_INT: s_nxt.flag = 1'b1;
				// RL9 interrupt first, then reset
				M_BOTH: begin
					// RL7 unserviced flag resets
					if (s_r.flag) begin
						s_nxt.srst = 1'b1;
					end else begin
						// RL5 first timeout flags
						s_nxt.flag = 1'b1;
					end
				end
				// RL14 reset only mode
				M_RST: s_nxt.srst = 1'b1;
				default: s_nxt.srst = 1'b0;
			endcase
			if (s_nxt.srst) begin
				s_nxt.watchdog_reset_flag          = 1'b1;
				s_nxt.ist[EV_SRST]  = 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			s_r      <= '0;
			s_r.flag <= CTRL_RESET[B_FLAG];
			s_r.ist  <= EV_RESET;
			s_r.ien  <= EV_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs
	assign WB_DAT_O        = {24'h000000, s_r.rdat};
	assign WB_ACK_O        = s_r.ack;
	// RL3 gated interrupt request
	assign TIMEOUT_IRQ_REQ = GLOBAL_IE & ie_eff & s_r.flag;
	assign SYS_RESET_REQ   = s_r.srst;
	assign IRQ             = |(s_r.ist & s_r.ien);

	// checks
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (RST);

	logic wr_ctrl;
	assign wr_ctrl = wr && (adr == A_CTRL);

	sequence s_first_tout;
		mode == M_BOTH && tout && !s_r.flag;
	endsequence

	sequence s_flag_only;
		s_r.flag && !SYS_RESET_REQ;
	endsequence

	a_flag_set_int: assert property (mode == M_INT && tout |=> s_r.flag) // RL1
		else $error("flag not set on interrupt timeout");
	a_flag_clr_vec: assert property (VECTOR_ACK && !tout |=> !s_r.flag) // RL2
		else $error("flag not cleared by vector");
	a_req_gated: assert property (mode == M_INT && tout && GLOBAL_IE && ie_eff
		##1 GLOBAL_IE |-> TIMEOUT_IRQ_REQ) // RL3
		else $error("interrupt request missing");
	a_int_no_rst: assert property (mode == M_INT && tout |=> !SYS_RESET_REQ) // RL4
		else $error("reset in interrupt mode");
	a_both_first: assert property (s_first_tout |=> s_flag_only) // RL5
		else $error("first combined timeout wrong");
	a_both_vector: assert property (VECTOR_ACK && mode == M_BOTH && !tout
		|=> !s_r.ie && !s_r.flag && mode == M_RST) // RL6
		else $error("vector did not fall back to reset mode");
	a_both_second: assert property (mode == M_BOTH && tout && s_r.flag
		|=> SYS_RESET_REQ ##1 !SYS_RESET_REQ) // RL7
		else $error("second timeout did not reset");
	a_ce_expire: assert property ($fell(win_open) |-> $past(wr_ctrl && d[B_CE], 5)) // RL11
		else $error("change enable wrong length");
	a_wde_guard: assert property (wr_ctrl && !d[B_WDE] && (!win_open || s_r.watchdog_reset_flag)
		|=> s_r.system_reset_enable == $past(s_r.system_reset_enable)) // RL10
		else $error("reset enable cleared outside window");
	a_watchdog_reset_flag_force: assert property (s_r.watchdog_reset_flag |-> ctrl_rd[B_WDE] && mode != M_STOP) // RL12
		else $error("reset flag did not force enable");
	a_fuse_reset: assert property (ALWAYS_ON_FUSE && tout |=> SYS_RESET_REQ && !s_r.ie) // RL18
		else $error("fuse did not force reset");
	a_stopped: assert property (mode == M_STOP ##1 mode == M_STOP |-> !tout) // RL14
		else $error("timeout while stopped");
	a_restart: assert property (WDR_EXEC |=> !tout) // RL19
		else $error("restart did not clear counter");

	// bus handshake: one ack per request, read data held between reads
	a_ack_answer: assert property (req && !WB_ACK_O |=> WB_ACK_O)
		else $error("no ack after request");
	a_ack_drop: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack held longer than one cycle");
	a_rdat_hold: assert property (!(req && !WB_ACK_O) |=> $stable(WB_DAT_O))
		else $error("read data moved without a read");
	a_iclr_reads_zero: assert property (req && !WB_ACK_O && adr == A_ICLR
		|=> WB_DAT_O == 32'h00000000)
		else $error("clear register did not read zero");

	// flag and event bits: set wins, cleared only by their own causes
	a_flag_w1c: assert property (wr_ctrl && d[B_FLAG] && !tout |=> !s_r.flag) // RL2
		else $error("writing one did not clear flag");
	a_tout_event: assert property (tout |=> s_r.ist[EV_TOUT]) // RL16
		else $error("timeout event not recorded");
	a_ist_sticky: assert property (s_r.ist[EV_TOUT] && !(wr && adr == A_ICLR && d[EV_TOUT])
		|=> s_r.ist[EV_TOUT])
		else $error("timeout event lost");
	a_iclr_clears: assert property (wr && adr == A_ICLR && d[EV_TOUT] && !tout
		|=> !s_r.ist[EV_TOUT])
		else $error("event clear ignored");
	a_srst_event: assert property (SYS_RESET_REQ |-> s_r.ist[EV_SRST] && s_r.watchdog_reset_flag) // RL12
		else $error("reset request not recorded");
	a_watchdog_reset_flag_clear: assert property (wr && adr == A_RSTAT && !d[B_WATCHDOG_RESET_FLAG] && !tout // RL12
		|=> !s_r.watchdog_reset_flag)
		else $error("reset flag not cleared by write");

	// control field guards
	a_wde_set: assert property (wr_ctrl && d[B_WDE] |=> s_r.system_reset_enable) // RL10
		else $error("reset enable not set by write");
	a_ps_guard: assert property (wr_ctrl && !win_open |=> $stable(s_r.ps)) // RL10
		else $error("prescaler changed outside window");
	a_ps_load: assert property (wr_ctrl && win_open // RL13
		|=> s_r.ps == $past({d[B_P3], d[2:0]}))
		else $error("prescaler not loaded inside window");
	a_fuse_ie: assert property (ALWAYS_ON_FUSE && wr_ctrl |=> !s_r.ie) // RL18
		else $error("interrupt enable set under fuse");
	a_ie_direct: assert property (wr_ctrl && !ALWAYS_ON_FUSE && !VECTOR_ACK
		|=> s_r.ie == $past(d[B_IE]))
		else $error("interrupt enable not written");
	a_vec_ie_keep: assert property (VECTOR_ACK && mode == M_INT && !wr_ctrl |=> s_r.ie) // RL4
		else $error("vector dropped enable in interrupt mode");

	// change window: opened by one write, held for exactly its length
	sequence s_ce_write;
		wr_ctrl && d[B_CE];
	endsequence

	sequence s_window_held;
		win_open [*4];
	endsequence

	a_ce_window: assert property (s_ce_write |=> s_window_held) // RL11
		else $error("change window closed early");
	a_win_max: assert property (s_r.win <= CE_WINDOW) // RL11
		else $error("change window longer than allowed");

	// counter events only follow oscillator ticks and stop on restart
	a_tout_tick: assert property (tout |-> $past(tick)) // RL16
		else $error("timeout without oscillator tick");
	a_rst_only: assert property (mode == M_RST && tout |=> SYS_RESET_REQ) // RL14
		else $error("reset mode timeout did not reset");
	a_srst_restart: assert property (SYS_RESET_REQ |=> !tout) // RL19
		else $error("counter not restarted after reset request");
endmodule

// *** testbench/testbench.sv ***
// watchdog control and timeout: self-checking bench around the core model
// assumes the shortest count shortened to 4 and an oscillator of 8 cycles
`timescale 1ns/100ps
`define CHK(w, e, s) begin n_checks++; if ((s) !== (e)) begin n_fail++; \
	$display("wrong value %s expected %h seen %h", w, e, s); end end
`define WAITFOR(c) begin cyc_n = 0; while (!(c) && cyc_n < 2000) begin \
	@(posedge SYS_CLK); cyc_n++; end `CHK("wait", 1'b1, c) end
module testbench
	import wct_pkg::*;
;
	localparam int BASE = 4;
	logic        SYS_CLK = 1'b0;
	logic        RST = 1'b1, CYC = 1'b0, STB = 1'b0, WE = 1'b0, OSC = 1'b0;
	logic        FUSE = 1'b0, WDR = 1'b0, GIE = 1'b0;
	logic [7:0]  ADR = 8'h00, q;
	logic [31:0] DAT = 32'h0, seed = 32'h533A;
	logic [3:0]  lag = 4'h0;
	logic [2:0]  osc_n = 3'h0, p;
	wire  [31:0] DAT_O;
	wire         ACK, REQ, SRST, IRQ, VEC;
	int          n_fail = 0, n_checks = 0, edges = 0, n_srst = 0, cyc_n;

	wct_watchdog #(.BASE_CYCLES(BASE)) i_wct_watchdog (
		.SYS_CLK(SYS_CLK), .RST(RST), .WB_CYC_I(CYC), .WB_STB_I(STB),
		.WB_WE_I(WE), .WB_ADR_I(ADR), .WB_SEL_I(4'h1), .WB_DAT_I(DAT),
		.WB_DAT_O(DAT_O), .WB_ACK_O(ACK), .WDT_OSC(OSC), .ALWAYS_ON_FUSE(FUSE),
		.WDR_EXEC(WDR), .VECTOR_ACK(VEC), .GLOBAL_IE(GIE),
		.TIMEOUT_IRQ_REQ(REQ), .SYS_RESET_REQ(SRST), .IRQ(IRQ));
	wct_core_model i_wct_core_model (.clk(SYS_CLK), .rst(RST), .req(REQ),
		.lag(lag), .vec(VEC));

	initial begin
		forever #5 SYS_CLK = ~SYS_CLK;
	end

	// oscillator at one eighth of the core clock, rises counted per restart
	always @(posedge SYS_CLK) begin
		osc_n <= osc_n + 3'h1;
		OSC <= osc_n[2];
		edges <= WDR ? 0 : edges + int'(osc_n == 3'h3);
		n_srst <= n_srst + int'(SRST === 1'b1);
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	// one classic cycle, held until ack is sampled, then one idle cycle
	task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		seed = xs(seed);
		CYC <= 1'b1;
		STB <= 1'b1;
		WE <= w;
		ADR <= a;
		DAT <= {seed[31:8], d};
		do begin
			@(posedge SYS_CLK);
			n++;
		end while (ACK !== 1'b1 && n < 20);
		q = DAT_O[7:0];
		CYC <= 1'b0;
		STB <= 1'b0;
		`CHK("ack", 1'b1, ACK)
		@(posedge SYS_CLK);
	endtask

	task rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		wb(1'b0, a, 8'h00);
		`CHK("read", e, q & m)
	endtask

	task wdr_pulse;
		WDR <= 1'b1;
		@(posedge SYS_CLK);
		WDR <= 1'b0;
	endtask

	task end_of_test;
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		#200000;
		n_fail++;
		end_of_test();
	end

	initial begin
		repeat (20) @(posedge SYS_CLK);
		RST <= 1'b0;
		@(posedge SYS_CLK);
		rd(A_CTRL, 8'hFF, CTRL_RESET);
		rd(8'h1C, 8'hFF, 8'h00);
		// fuse locks the enables
		FUSE <= 1'b1;
		wdr_pulse();
		wb(1'b1, A_CTRL, 8'h40);
		rd(A_CTRL, 8'hFF, 8'h08);
		FUSE <= 1'b0;
		wb(1'b1, A_CTRL, 8'h00);
		p = {2'h0, seed[4]};
		lag <= seed[3:0];
		// timed change into interrupt mode with a random prescale
		wb(1'b1, A_CTRL, 8'h18);
		wb(1'b1, A_CTRL, {5'h08, p});
		rd(A_CTRL, 8'hFF, {5'h08, p});
		wb(1'b1, A_IEN, 8'h01);
		repeat (2) begin
			wdr_pulse();
			`WAITFOR(IRQ === 1'b1)
			`CHK("edges", 1'b1, edges == (BASE << p) || edges == (BASE << p) - 1)
			`CHK("req", 1'b0, REQ)
			rd(A_CTRL, 8'hFF, {5'h18, p});
			rd(A_ISTAT, 8'h01, 8'h01);
			wb(1'b1, A_ICLR, 8'h01);
			`CHK("irq", 1'b0, IRQ)
			wb(1'b1, A_CTRL, {5'h18, p});
			rd(A_CTRL, 8'hFF, {5'h08, p});
		end
		`CHK("resets", 0, n_srst)
		// the core takes the vector once the global enable is set
		GIE <= 1'b1;
		wdr_pulse();
		`WAITFOR(REQ === 1'b1)
		`WAITFOR(VEC === 1'b1)
		rd(A_CTRL, 8'hFF, {5'h08, p});
		// combined mode left unserviced
		GIE <= 1'b0;
		wb(1'b1, A_ICLR, 8'h01);
		wb(1'b1, A_CTRL, {5'h09, p});
		wdr_pulse();
		`WAITFOR(IRQ === 1'b1)
		rd(A_CTRL, 8'hFF, {5'h19, p});
		`CHK("resets", 0, n_srst)
		`WAITFOR(SRST === 1'b1)
		rd(A_RSTAT, 8'h01, 8'h01);
		wdr_pulse();
		wb(1'b1, A_CTRL, 8'h18);
		wb(1'b1, A_CTRL, {5'h10, p});
		rd(A_CTRL, 8'h08, 8'h08);
		wb(1'b1, A_RSTAT, 8'h00);
		wb(1'b1, A_CTRL, 8'h18);
		wb(1'b1, A_CTRL, {5'h10, p});
		rd(A_CTRL, 8'hFF, {5'h00, p});
		// late second write after the window closed
		wdr_pulse();
		wb(1'b1, A_CTRL, {5'h03, p});
		repeat (6) @(posedge SYS_CLK);
		wb(1'b1, A_CTRL, 8'h00);
		rd(A_CTRL, 8'hFF, {5'h01, p});
		// combined mode serviced, then reset operation
		GIE <= 1'b1;
		wb(1'b1, A_ICLR, 8'h03);
		wb(1'b1, A_CTRL, {5'h09, p});
		wdr_pulse();
		`WAITFOR(VEC === 1'b1)
		repeat (2) @(posedge SYS_CLK);
		rd(A_CTRL, 8'hFF, {5'h01, p});
		`WAITFOR(SRST === 1'b1)
		rd(A_ISTAT, 8'h02, 8'h02);
		end_of_test();
	end
endmodule

// *** testbench/wct_core_model.sv ***
// watchdog control and timeout: core model that takes the timeout interrupt
// assumes req is sampled on the rising edge of clk
`timescale 1ns/100ps
module wct_core_model (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// interrupt request in, vector execution out
	input  wire logic       req,
	input  wire logic [3:0] lag,
	output logic            vec
);
	int wait_n;
	always_ff @(posedge clk) begin
		vec <= 1'b0;
		if (rst || !req || vec) begin
			wait_n <= 0;
		end else if (wait_n >= int'(lag)) begin
			vec <= 1'b1;
			wait_n <= 0;
		end else begin
			wait_n <= wait_n + 1;
		end
	end
endmodule
